// ==== common/axis_cfg.svh ====
// Constants for the axis homing and supervision block: register indices,
// reset values and timing. Assumes a 10 MHz clock and a 32-bit register bus.
// Functional notes
// - Mode 1 left only; mode 2 right then left.
// - Mode 3 right then left both sides; 4 both.
// - Modes 5/6 seek home, reverse at limit.
// - Modes 7/8 seek home, limits ignored.
// - Plus 128 inverts home switch polarity.
// - Plus 64 uses right reference switch.
// - Separate coarse and fine search speeds.
// - Modes 2/3 report limit switch distance.
// - Latch position just before clearing it.
// - Boost current when ramping; zero means run current.
// - Full steps per revolution, 16 bits, default 200.
// - Zero standby current selects standstill coil option.
// - Read-only load value 0 to 1023.
// - Error bit 0 stall, bit 1 deviation.
// - Errors clear on read or motion command.
// - Writable signed encoder count, 16-bit resolution.
// - Stop on position deviation; zero limit disables.
// - Stop on velocity deviation; zero limit disables.
// - Power down after standstill delay in 10 ms.
// - Stall stop only above velocity threshold.
`ifndef AXIS_CFG_SVH
`define AXIS_CFG_SVH
`define IDX_RUN_CURRENT 8'h06
`define IDX_STANDBY_CURRENT 8'h07
`define IDX_STALL_SPEED 8'hb5
`define IDX_HOMING_MODE 8'hc1
`define IDX_COARSE_SPEED 8'hc2
`define IDX_FINE_SPEED 8'hc3
`define IDX_SWITCH_DIST 8'hc4
`define IDX_LAST_HOME 8'hc5
`define IDX_BOOST 8'hc8
`define IDX_STEPS_REV 8'hca
`define IDX_STANDSTILL 8'hcc
`define IDX_LOAD 8'hce
`define IDX_ERR_FLAGS 8'hcf
`define IDX_DRV_FLAGS 8'hd0
`define IDX_ENC_COUNT 8'hd1
`define IDX_ENC_RES 8'hd2
`define IDX_POS_DEV 8'hd4
`define IDX_VEL_DEV 8'hd5
`define IDX_PD_DELAY 8'hd6
`define RST_HOMING_MODE 8'h01
`define RST_STEPS_REV 16'h00c8
`define RST_PD_DELAY 16'h00c8
`define RST_ENC_RES 16'h00c8
`define RST_RUN_CURRENT 8'h80
`define ERR_STALL_BIT 0
`define ERR_DEV_BIT 1
`define HOME_INV_BIT 7
`define HOME_RIGHT_BIT 6
`define CLK_PERIOD_NS 100
`define PD_UNIT_NS 10000000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== common/axis_pkg.sv ====
// Types shared by the homing sequencer and the axis top.
// Assumes the constants header is included where numbers are needed.
package axis_pkg;
	typedef enum logic [2:0] {
		h_idle,
		h_far,
		h_coarse,
		h_leave,
		h_return
	} home_state_e;
	typedef logic [1:0] coil_mode_t;
endpackage

// ==== src/axis_homing_and_supervision.sv ====
// Axis homing and motion supervision with an AXI4-Lite register slave.
// Assumes ramp logic supplies positions, velocities and phase flags, and
// encoder steps arrive as one-cycle pulses synchronous to clk.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "axis_cfg.svh"
module axis_homing_and_supervision
	import axis_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int PD_TICK_CYCLES = `PD_UNIT_NS / `CLK_PERIOD_NS
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic reference_search_command,
	input wire logic motion_cmd,
	input wire logic left_sw,
	input wire logic right_sw,
	input wire logic home_sw,
	input wire logic signed [31:0] pos_actual,
	input wire logic signed [31:0] vel_actual,
	input wire logic signed [31:0] vel_desired,
	input wire logic signed [31:0] vel_measured,
	input wire logic ramping,
	input wire logic standstill,
	input wire logic [9:0] load_value,
	input wire logic [7:0] drv_flags,
	input wire logic enc_step,
	input wire logic enc_dir_pos,
	output logic stop_motor,
	output logic home_busy,
	output logic home_dir_pos,
	output logic [23:0] home_speed,
	output logic pos_clear,
	output logic [7:0] motor_current,
	output coil_mode_t coil_mode
);
	logic [7:0] homing_mode;
	logic [23:0] homing_coarse_speed;
	logic [23:0] homing_fine_speed;
	logic [31:0] limit_switch_distance;
	logic [31:0] last_home_position;
	logic [7:0] accel_boost_current;
	logic [15:0] steps_per_revolution;
	logic [1:0] standstill_option;
	logic [1:0] sticky_error_flags;
	logic signed [31:0] encoder_count;
	logic [15:0] encoder_counts_per_rev;
	logic [31:0] position_deviation_limit;
	logic [31:0] velocity_deviation_limit;
	logic [15:0] power_down_delay;
	logic [7:0] run_current;
	logic [7:0] standby_current;
	logic [31:0] stall_speed;

	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [7:0] wr_idx;
	logic wr_ok;
	logic [7:0] rd_idx;
	logic rd_ok;
	logic [31:0] rd_val;
	logic err_read;

	logic seq_busy;
	logic seq_dir;
	logic seq_fine;
	logic seq_far;
	logic seq_zero;
	logic signed [31:0] far_pos;
	logic dev_trip;
	logic vel_trip;
	logic stall_trip;
	logic [31:0] tick_cnt;
	logic [15:0] unit_cnt;
	logic powered_down;
	logic [31:0] next_wdata;

	// Absolute difference of two signed values, one bit wider to avoid overflow.
	function automatic logic [32:0] abs_diff(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [32:0] d;
		d = 33'(a) - 33'(b);
		return d[32] ? 33'(-d) : 33'(d);
	endfunction

	// Word address to register index; returns 1 when the index is mapped.
	function automatic logic idx_mapped(input logic [7:0] i);
		case (i)
			`IDX_RUN_CURRENT, `IDX_STANDBY_CURRENT, `IDX_STALL_SPEED,
			`IDX_HOMING_MODE, `IDX_COARSE_SPEED, `IDX_FINE_SPEED,
			`IDX_SWITCH_DIST, `IDX_LAST_HOME, `IDX_BOOST, `IDX_STEPS_REV,
			`IDX_STANDSTILL, `IDX_LOAD, `IDX_ERR_FLAGS, `IDX_DRV_FLAGS,
			`IDX_ENC_COUNT, `IDX_ENC_RES, `IDX_POS_DEV, `IDX_VEL_DEV,
			`IDX_PD_DELAY: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Write channel: address and data may arrive in either order.
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = aw_addr[ADDR_W-1:2] < ADDR_W'(256) ? 8'(aw_addr[ADDR_W-1:2]) : 8'h00;
	assign wr_ok = (aw_addr[ADDR_W-1:2] < ADDR_W'(256)) && idx_mapped(wr_idx)
		&& aw_addr[1:0] == 2'b00;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign next_wdata = w_data;

	// Software configuration registers.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			homing_mode <= `RST_HOMING_MODE;
			homing_coarse_speed <= 24'h0;
			homing_fine_speed <= 24'h0;
			accel_boost_current <= 8'h00;
			steps_per_revolution <= `RST_STEPS_REV;
			standstill_option <= 2'h0;
			encoder_counts_per_rev <= `RST_ENC_RES;
			position_deviation_limit <= 32'h0;
			velocity_deviation_limit <= 32'h0;
			power_down_delay <= `RST_PD_DELAY;
			run_current <= `RST_RUN_CURRENT;
			standby_current <= 8'h00;
			stall_speed <= 32'h0;
		end else if (wr_go && wr_ok) begin
			case (wr_idx)
				`IDX_HOMING_MODE: homing_mode <= 8'(merge(32'(homing_mode), next_wdata, w_strb));
				`IDX_COARSE_SPEED: homing_coarse_speed <=
					24'(merge(32'(homing_coarse_speed), next_wdata, w_strb));
				`IDX_FINE_SPEED: homing_fine_speed <=
					24'(merge(32'(homing_fine_speed), next_wdata, w_strb));
				`IDX_BOOST: accel_boost_current <=
					8'(merge(32'(accel_boost_current), next_wdata, w_strb));
				`IDX_STEPS_REV: steps_per_revolution <=
					16'(merge(32'(steps_per_revolution), next_wdata, w_strb));
				`IDX_STANDSTILL: standstill_option <=
					2'(merge(32'(standstill_option), next_wdata, w_strb));
				`IDX_ENC_RES: encoder_counts_per_rev <=
					16'(merge(32'(encoder_counts_per_rev), next_wdata, w_strb));
				`IDX_POS_DEV: position_deviation_limit <=
					merge(position_deviation_limit, next_wdata, w_strb);
				`IDX_VEL_DEV: velocity_deviation_limit <=
					merge(velocity_deviation_limit, next_wdata, w_strb);
				`IDX_PD_DELAY: power_down_delay <=
					16'(merge(32'(power_down_delay), next_wdata, w_strb));
				`IDX_RUN_CURRENT: run_current <= 8'(merge(32'(run_current), next_wdata, w_strb));
				`IDX_STANDBY_CURRENT: standby_current <=
					8'(merge(32'(standby_current), next_wdata, w_strb));
				`IDX_STALL_SPEED: stall_speed <= merge(stall_speed, next_wdata, w_strb);
				default: ;
			endcase
		end
	end

	// Encoder counter; a software write takes priority over a step.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			encoder_count <= 32'sh0;
		end else if (wr_go && wr_ok && wr_idx == `IDX_ENC_COUNT) begin
			encoder_count <= merge(encoder_count, next_wdata, w_strb);
		end else if (enc_step) begin
			encoder_count <= enc_dir_pos ? encoder_count + 32'sd1 : encoder_count - 32'sd1;
		end
	end

	// Read channel.
	assign rd_idx = s_axi_araddr[ADDR_W-1:2] < ADDR_W'(256) ? 8'(s_axi_araddr[ADDR_W-1:2]) : 8'h00;
	assign rd_ok = (s_axi_araddr[ADDR_W-1:2] < ADDR_W'(256)) && idx_mapped(rd_idx)
		&& s_axi_araddr[1:0] == 2'b00;

	always_comb begin
		case (rd_idx)
			`IDX_RUN_CURRENT: rd_val = 32'(run_current);
			`IDX_STANDBY_CURRENT: rd_val = 32'(standby_current);
			`IDX_STALL_SPEED: rd_val = stall_speed;
			`IDX_HOMING_MODE: rd_val = 32'(homing_mode);
			`IDX_COARSE_SPEED: rd_val = 32'(homing_coarse_speed);
			`IDX_FINE_SPEED: rd_val = 32'(homing_fine_speed);
			`IDX_SWITCH_DIST: rd_val = limit_switch_distance;
			`IDX_LAST_HOME: rd_val = last_home_position;
			`IDX_BOOST: rd_val = 32'(accel_boost_current);
			`IDX_STEPS_REV: rd_val = 32'(steps_per_revolution);
			`IDX_STANDSTILL: rd_val = 32'(standstill_option);
			`IDX_LOAD: rd_val = 32'(load_value);
			`IDX_ERR_FLAGS: rd_val = 32'(sticky_error_flags);
			`IDX_DRV_FLAGS: rd_val = 32'(drv_flags);
			`IDX_ENC_COUNT: rd_val = encoder_count;
			`IDX_ENC_RES: rd_val = 32'(encoder_counts_per_rev);
			`IDX_POS_DEV: rd_val = position_deviation_limit;
			`IDX_VEL_DEV: rd_val = velocity_deviation_limit;
			`IDX_PD_DELAY: rd_val = 32'(power_down_delay);
			default: rd_val = 32'h0;
		endcase
	end

	assign err_read = s_axi_arvalid && s_axi_arready && rd_ok && rd_idx == `IDX_ERR_FLAGS;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? rd_val : 32'h0;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	homing_sequencer u_seq (
		.clk(clk),
		.rst_b(rst_b),
		.start(reference_search_command),
		.mode(homing_mode),
		.left_sw(left_sw),
		.right_sw(right_sw),
		.home_sw(home_sw),
		.busy(seq_busy),
		.dir_pos(seq_dir),
		.fine(seq_fine),
		.far_pulse(seq_far),
		.zero_pulse(seq_zero)
	);

	// Homing outputs and captures.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			home_busy <= 1'b0;
			home_dir_pos <= 1'b0;
			home_speed <= 24'h0;
			pos_clear <= 1'b0;
			far_pos <= 32'sh0;
			last_home_position <= 32'h0;
			limit_switch_distance <= 32'h0;
		end else begin
			home_busy <= seq_busy;
			home_dir_pos <= seq_dir;
			home_speed <= !seq_busy ? 24'h0 : seq_fine ? homing_fine_speed : homing_coarse_speed;
			pos_clear <= seq_zero;
			if (seq_far) begin
				far_pos <= pos_actual;
			end
			if (pos_clear) begin
				// Latched at the edge where the ramp logic clears, so the kept value is the wiped one.
				last_home_position <= pos_actual;
				if (homing_mode[5:0] == 6'd2 || homing_mode[5:0] == 6'd3) begin
					limit_switch_distance <= 32'(abs_diff(pos_actual, far_pos));
				end
			end
		end
	end

	// Supervision trips; a deviation limit of zero switches that check off.
	assign dev_trip = position_deviation_limit != 32'h0
		&& abs_diff(pos_actual, encoder_count) > 33'(position_deviation_limit);
	assign vel_trip = velocity_deviation_limit != 32'h0
		&& abs_diff(vel_desired, vel_measured) > 33'(velocity_deviation_limit);
	assign stall_trip = abs_diff(vel_actual, 32'sh0) > 33'(stall_speed)
		&& load_value == 10'h000;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stop_motor <= 1'b0;
		end else begin
			stop_motor <= dev_trip || vel_trip || stall_trip;
		end
	end

	// Sticky errors: a new trip in the clearing cycle still sets its bit.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sticky_error_flags <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == `ERR_STALL_BIT && stall_trip)
					|| (i == `ERR_DEV_BIT && (dev_trip || vel_trip))) begin
					sticky_error_flags[i] <= 1'b1;
				end else if (err_read || motion_cmd || reference_search_command) begin
					sticky_error_flags[i] <= 1'b0;
				end
			end
		end
	end

	// Standstill timer in 10 ms units; long counts are parameters.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_cnt <= 32'h0;
			unit_cnt <= 16'h0;
			powered_down <= 1'b0;
		end else if (!standstill || seq_busy) begin
			tick_cnt <= 32'h0;
			unit_cnt <= 16'h0;
			powered_down <= 1'b0;
		end else if (unit_cnt >= power_down_delay) begin
			powered_down <= 1'b1;
		end else if (tick_cnt >= 32'(PD_TICK_CYCLES - 1)) begin
			tick_cnt <= 32'h0;
			unit_cnt <= unit_cnt + 16'h1;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	// Current selection and coil handling at rest.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			motor_current <= 8'h00;
			coil_mode <= 2'h0;
		end else begin
			if (ramping) begin
				motor_current <= accel_boost_current != 8'h00 ? accel_boost_current : run_current;
			end else if (powered_down) begin
				motor_current <= standby_current;
			end else begin
				motor_current <= run_current;
			end
			coil_mode <= (powered_down && standby_current == 8'h00) ? standstill_option : 2'h0;
		end
	end
endmodule

// ==== src/homing_sequencer.sv ====
// Reference search sequencer for one axis.
// Assumes switch inputs are synchronous and high when the switch is active.
`timescale 1ns/1ps
`include "axis_cfg.svh"
module homing_sequencer
	import axis_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [7:0] mode,
	input wire logic left_sw,
	input wire logic right_sw,
	input wire logic home_sw,
	output logic busy,
	output logic dir_pos,
	output logic fine,
	output logic far_pulse,
	output logic zero_pulse
);
	home_state_e state;
	logic [7:0] m;
	logic [5:0] base;
	logic ref_hit;
	logic far_hit;
	logic tgt;
	logic both;

	assign base = m[5:0];
	assign ref_hit = m[`HOME_RIGHT_BIT] ? right_sw : left_sw;
	assign far_hit = m[`HOME_RIGHT_BIT] ? left_sw : right_sw;
	assign tgt = (base >= 6'd5) ? (home_sw ^ m[`HOME_INV_BIT]) : ref_hit;
	assign both = (base == 6'd3) || (base == 6'd4);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= h_idle;
			m <= 8'h00;
			busy <= 1'b0;
			dir_pos <= 1'b0;
			fine <= 1'b0;
			far_pulse <= 1'b0;
			zero_pulse <= 1'b0;
		end else begin
			far_pulse <= 1'b0;
			zero_pulse <= 1'b0;
			case (state)
				h_idle: begin
					fine <= 1'b0;
					if (start && mode[5:0] >= 6'd1 && mode[5:0] <= 6'd8) begin
						m <= mode;
						busy <= 1'b1;
						// Modes 2 and 3 run to the far switch first.
						if (mode[5:0] == 6'd2 || mode[5:0] == 6'd3) begin
							state <= h_far;
							dir_pos <= !mode[`HOME_RIGHT_BIT];
						end else begin
							state <= h_coarse;
							case (mode[5:0])
								6'd5, 6'd8: dir_pos <= 1'b0;
								6'd6, 6'd7: dir_pos <= 1'b1;
								default: dir_pos <= mode[`HOME_RIGHT_BIT];
							endcase
						end
					end
				end
				h_far: begin
					if (far_hit) begin
						far_pulse <= 1'b1;
						dir_pos <= m[`HOME_RIGHT_BIT];
						state <= h_coarse;
					end
				end
				h_coarse: begin
					if (tgt) begin
						dir_pos <= !dir_pos;
						fine <= 1'b1;
						state <= h_leave;
					end else if (base == 6'd5 && left_sw) begin
						dir_pos <= 1'b1;
					end else if (base == 6'd6 && right_sw) begin
						dir_pos <= 1'b0;
					end
				end
				h_leave: begin
					if (!tgt) begin
						if (both) begin
							dir_pos <= !dir_pos;
							state <= h_return;
						end else begin
							zero_pulse <= 1'b1;
							busy <= 1'b0;
							state <= h_idle;
						end
					end
				end
				h_return: begin
					if (tgt) begin
						zero_pulse <= 1'b1;
						busy <= 1'b0;
						state <= h_idle;
					end
				end
				default: state <= h_idle;
			endcase
		end
	end
endmodule

// ==== test/axis_homing_and_supervision_assertions.sv ====
// Checker bound to the axis top.
// Assumes one clock and reset rst_b.
`timescale 1ns/1ps
module axis_supervision_checker
	import axis_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic standstill,
	input wire logic stop_motor,
	input wire logic home_busy,
	input wire logic [23:0] home_speed,
	input wire logic pos_clear,
	input wire coil_mode_t coil_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp not held");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata not held");
	AST_R_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("rvalid unasked");
	AST_AW_CAUSE: assert property (s_axi_awready |-> $past(s_axi_awvalid))
		else $error("awready unasked");
	AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready too long");
	AST_PCLR_ONE: assert property (pos_clear |=> !pos_clear)
		else $error("pos_clear too long");
	AST_PCLR_END: assert property (pos_clear |-> ##[0:3] !home_busy)
		else $error("busy after clear");
	AST_IDLE_SPEED: assert property (!home_busy |-> home_speed == 24'h0)
		else $error("idle speed");
	AST_COIL_RUN: assert property (!standstill ##1 !standstill |=> coil_mode == 2'b00)
		else $error("coil option moving");
	cover property (pos_clear);
	cover property (stop_motor);
	cover property (coil_mode != 2'b00);
endmodule
bind axis_homing_and_supervision axis_supervision_checker i_axis_supervision_checker (.*);

// ==== test/axis_homing_and_supervision_test.sv ====
// Bench: registers, homing, supervision, encoder, currents.
// Assumes the axis model drives the switches.
`timescale 1ns/1ps
`include "axis_cfg.svh"
module axis_homing_and_supervision_test;
	logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0] s_axi_bresp, s_axi_rresp, coil_mode, r;
	logic cmd, motion_cmd, left_sw, right_sw, home_sw, ramping, standstill, enc_step, enc_dir_pos;
	logic signed [31:0] pos_actual, vel_actual, vel_desired, vel_measured, preset_pos;
	logic [9:0] load_value;
	logic [7:0] drv_flags, motor_current;
	logic stop_motor, home_busy, home_dir_pos, pos_clear, preset;
	logic [23:0] home_speed;
	int num_errors, tests_run, cycles;
	logic [7:0] modes [11] = '{8'd1, 8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd7, 8'd8, 8'd65, 8'd68, 8'd135};
	int starts [11] = '{20, 20, 20, 20, 5, 20, 0, 30, 20, 20, 12};
	logic dirs [11] = '{0, 1, 1, 0, 0, 1, 1, 0, 1, 1, 1};
	axis_homing_and_supervision #(.ADDR_W(12), .PD_TICK_CYCLES(4)) i_axis_homing_and_supervision (
		.clk, .rst_b, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_search_command(cmd),
		.motion_cmd, .left_sw, .right_sw, .home_sw, .pos_actual, .vel_actual, .vel_desired,
		.vel_measured, .ramping, .standstill, .load_value, .drv_flags, .enc_step, .enc_dir_pos,
		.stop_motor, .home_busy, .home_dir_pos, .home_speed, .pos_clear, .motor_current, .coil_mode);
	axis_partner i_axis_partner (.clk, .rst_b, .busy(home_busy), .dir_pos(home_dir_pos),
		.clr(pos_clear), .preset, .preset_pos, .pos(pos_actual), .left_sw, .right_sw, .home_sw);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			$display("ERROR at %0t: timeout", $time);
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic a, w, done = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(negedge clk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid;
			if (done) chk(32'(s_axi_bresp), 32'(`RESP_OKAY));
			@(posedge clk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (done) s_axi_bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
		logic a, done = 1'b0;
		@(posedge clk);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(negedge clk);
			a = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (a) s_axi_arvalid <= 1'b0;
			if (done) s_axi_rready <= 1'b0;
		end
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] resp;
		rd(idx, d, resp);
		chk(d, exp);
		chk(32'(resp), 32'(`RESP_OKAY));
	endtask
	task automatic look();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic trip(input logic e);
		look();
		chk(32'(stop_motor), 32'(e));
	endtask
	task automatic home(input logic [7:0] m, input int start, input logic dir);
		logic seen = 1'b0, fine_seen = 1'b0;
		logic [31:0] cap = 32'h0;
		int n = 4;
		wr(`IDX_HOMING_MODE, {24'h0, m});
		preset <= 1'b1;
		preset_pos <= start;
		@(posedge clk);
		preset <= 1'b0;
		cmd <= 1'b1;
		@(posedge clk);
		cmd <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(32'(home_busy), 32'h1);
		chk(32'(home_dir_pos), 32'(dir));
		chk(32'(home_speed), 32'h300);
		while (n > 0) begin
			@(negedge clk);
			if (home_busy) n = 4;
			else n--;
			if (home_busy && home_speed === 24'h40) fine_seen = 1'b1;
			if (pos_clear === 1'b1) begin
				seen = 1'b1;
				cap = pos_actual;
			end
		end
		chk(32'(seen), 32'h1);
		if (m[5:0] <= 6'd4) chk(32'(fine_seen), 32'h1);
		rd_chk(`IDX_LAST_HOME, cap);
	endtask
	initial begin
		{rst_b, cmd, motion_cmd, ramping, standstill, enc_step, enc_dir_pos, preset} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{vel_actual, vel_desired, vel_measured, preset_pos} = '0;
		load_value = 10'h3ff;
		drv_flags = 8'ha5;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(`IDX_STEPS_REV, 32'd200);
		rd_chk(`IDX_PD_DELAY, 32'd200);
		wr(`IDX_STEPS_REV, 32'h1_2345);
		rd_chk(`IDX_STEPS_REV, 32'h2345);
		rd_chk(`IDX_LOAD, 32'h3ff);
		rd_chk(`IDX_DRV_FLAGS, 32'ha5);
		rd(8'hff, v, r);
		chk(v, 32'h0);
		chk(32'(r), 32'(`RESP_SLVERR));
		$display("test registers done");
		wr(`IDX_COARSE_SPEED, 32'h300);
		wr(`IDX_FINE_SPEED, 32'h40);
		for (int i = 0; i < 11; i++) begin
			home(modes[i], starts[i], dirs[i]);
			if (i == 1 || i == 2) begin
				rd(`IDX_SWITCH_DIST, v, r);
				chk(32'(v >= 32'd42 && v <= 32'd48), 32'h1);
			end
		end
		$display("test homing done");
		wr(`IDX_STALL_SPEED, 32'd100);
		@(posedge clk);
		load_value <= 10'h0;
		vel_actual <= 32'sd101;
		trip(1'b1);
		@(posedge clk);
		vel_actual <= 32'sd100;
		trip(1'b0);
		rd_chk(`IDX_ERR_FLAGS, 32'h1);
		rd_chk(`IDX_ERR_FLAGS, 32'h0);
		@(posedge clk);
		preset <= 1'b1;
		preset_pos <= 32'sd0;
		@(posedge clk);
		preset <= 1'b0;
		wr(`IDX_ENC_COUNT, 32'd11);
		wr(`IDX_POS_DEV, 32'd10);
		trip(1'b1);
		wr(`IDX_POS_DEV, 32'd11);
		trip(1'b0);
		wr(`IDX_POS_DEV, 32'd0);
		trip(1'b0);
		@(posedge clk);
		motion_cmd <= 1'b1;
		@(posedge clk);
		motion_cmd <= 1'b0;
		rd_chk(`IDX_ERR_FLAGS, 32'h0);
		@(posedge clk);
		vel_measured <= 32'sd50;
		wr(`IDX_VEL_DEV, 32'd49);
		trip(1'b1);
		wr(`IDX_VEL_DEV, 32'd50);
		trip(1'b0);
		wr(`IDX_VEL_DEV, 32'd0);
		rd_chk(`IDX_ERR_FLAGS, 32'h2);
		$display("test supervision done");
		wr(`IDX_ENC_COUNT, 32'd1000);
		@(posedge clk);
		enc_dir_pos <= 1'b1;
		enc_step <= 1'b1;
		repeat (3) @(posedge clk);
		enc_dir_pos <= 1'b0;
		@(posedge clk);
		enc_step <= 1'b0;
		rd_chk(`IDX_ENC_COUNT, 32'd1002);
		wr(`IDX_ENC_COUNT, 32'hffff_fff0);
		rd_chk(`IDX_ENC_COUNT, 32'hffff_fff0);
		wr(`IDX_ENC_RES, 32'h1_ffff);
		rd_chk(`IDX_ENC_RES, 32'hffff);
		$display("test encoder done");
		wr(`IDX_RUN_CURRENT, 32'h40);
		wr(`IDX_BOOST, 32'h70);
		@(posedge clk);
		ramping <= 1'b1;
		look();
		chk(32'(motor_current), 32'h70);
		wr(`IDX_BOOST, 32'h0);
		look();
		chk(32'(motor_current), 32'h40);
		@(posedge clk);
		ramping <= 1'b0;
		wr(`IDX_PD_DELAY, 32'd3);
		wr(`IDX_STANDBY_CURRENT, 32'h0);
		for (int opt = 0; opt < 4; opt++) begin
			wr(`IDX_STANDSTILL, 32'(opt));
			@(posedge clk);
			standstill <= 1'b1;
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk(32'(coil_mode), 32'h0);
			repeat (15) @(posedge clk);
			@(negedge clk);
			chk(32'(coil_mode), 32'(opt));
			@(posedge clk);
			standstill <= 1'b0;
		end
		wr(`IDX_STANDBY_CURRENT, 32'h10);
		@(posedge clk);
		standstill <= 1'b1;
		repeat (21) @(posedge clk);
		@(negedge clk);
		chk(32'(motor_current), 32'h10);
		chk(32'(coil_mode), 32'h0);
		$display("test current done");
		print_verdict();
	end
endmodule

// ==== test/axis_partner.sv ====
// Axis model: position, limit and home switches.
// Assumes one step per clock while homing.
`timescale 1ns/1ps
module axis_partner (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic busy,
	input wire logic dir_pos,
	input wire logic clr,
	input wire logic preset,
	input wire logic signed [31:0] preset_pos,
	output logic signed [31:0] pos,
	output logic left_sw,
	output logic right_sw,
	output logic home_sw
);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pos <= 32'sd20;
		end else if (preset) begin
			pos <= preset_pos;
		end else if (clr) begin
			pos <= 32'sd0;
		end else if (busy) begin
			pos <= dir_pos ? pos + 32'sd1 : pos - 32'sd1;
		end
	end
	assign left_sw = pos <= -32'sd5;
	assign right_sw = pos >= 32'sd40;
	assign home_sw = pos >= 32'sd10 && pos <= 32'sd15;
endmodule
